// file: rtl/edge_cross.sv
// Three-stage synchroniser with change detector for an async level.
// Assumes the level holds for at least two destination clocks.
`timescale 1ns/1ps

module edge_cross (
  // Destination clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Asynchronous level
  input  wire logic level_in,
  // One-cycle pulse per accepted change
  output logic      change_q
);
  import link_init_pkg::*;

  logic s1_q, s2_q, s3_q;   // Synchroniser chain
  logic held_q, held_d;     // Last accepted level
  logic change_d;           // Next change pulse

  // A change counts once stages two and three agree
  always_comb begin
    held_d   = held_q;
    change_d = 1'b0;
    if (s2_q == s3_q && s3_q != held_q) begin
      held_d   = s3_q;
      change_d = 1'b1;
    end
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q     <= 1'b0;
      s2_q     <= 1'b0;
      s3_q     <= 1'b0;
      held_q   <= 1'b0;
      change_q <= 1'b0;
    end else begin
      s1_q     <= level_in;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      held_q   <= held_d;
      change_q <= change_d;
    end
  end

endmodule : edge_cross

// file: rtl/link_init_fsm.sv
// Exchange-level start-up and recovery state machine of a serial link.
// Assumes a character decoder on the link clock that pulses for each
// NULL, FCT and receive error, and raw data/strobe pins on d_in, s_in.
`timescale 1ns/1ps

module link_init_fsm #(
  parameter int TIMER_W = link_init_pkg::TIMER_W_DEF,
  parameter int DISC_W  = link_init_pkg::DISC_W_DEF
) (
  // System clock, reset and host enable
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  link_en,
  // Receive events on the link clock
  input  wire logic                  link_clk,
  input  wire logic                  rx_null_l,
  input  wire logic                  rx_fct_l,
  input  wire logic                  rx_err_l,
  // Raw data and strobe pins
  input  wire logic                  d_in,
  input  wire logic                  s_in,
  // Transmitter control
  output logic                       tx_en_q,
  output logic                       tx_null_q,
  output logic                       tx_fct_q,
  output logic                       fct_accept_q,
  // Status to the network level
  output logic                       running_q,
  output logic                       link_err_q,
  output link_init_pkg::link_state_t state_q
);
  import link_init_pkg::*;

  // Counters must hold the longest wait
  if (ERR_WAIT_CYC >= (1 << TIMER_W) ||
      START_WAIT_CYC >= (1 << TIMER_W) ||
      RESET_WAIT_CYC >= (1 << TIMER_W)) begin : g_bad_timer
    $error("TIMER_W too small for the state timeouts");
  end
  if (DISC_TIME_CYC >= (1 << DISC_W)) begin : g_bad_disc
    $error("DISC_W too small for the disconnect time");
  end

  // Last cycle counts of each wait
  localparam logic [TIMER_W-1:0] RST_LAST =
    TIMER_W'(RESET_WAIT_CYC - 1);
  localparam logic [TIMER_W-1:0] WAIT_LAST =
    TIMER_W'(ERR_WAIT_CYC - 1);
  localparam logic [TIMER_W-1:0] START_LAST =
    TIMER_W'(START_WAIT_CYC - 1);
  localparam logic [DISC_W-1:0]  DISC_LAST =
    DISC_W'(DISC_TIME_CYC);

  // True once a timer has run its full wait
  function automatic logic timer_done(
    input logic [TIMER_W-1:0] t,
    input logic [TIMER_W-1:0] last
  );
    timer_done = (t >= last);
  endfunction : timer_done

  // True for states in which the transmitter runs
  function automatic logic tx_state(input link_state_t s);
    tx_state = (s == ST_STARTED) || (s == ST_CONNECTING) ||
               (s == ST_RUN);
  endfunction : tx_state

  // ---------------- Link clock domain ----------------

  // Event toggles; a toggle survives a stopped link clock
  logic null_tgl_q, null_tgl_d;
  logic fct_tgl_q,  fct_tgl_d;
  logic err_tgl_q,  err_tgl_d;

  // Each decoder pulse flips its toggle
  always_comb begin
    null_tgl_d = null_tgl_q ^ rx_null_l;
    fct_tgl_d  = fct_tgl_q ^ rx_fct_l;
    err_tgl_d  = err_tgl_q ^ rx_err_l;
  end

  // Toggle registers on the link clock
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      null_tgl_q <= 1'b0;
      fct_tgl_q  <= 1'b0;
      err_tgl_q  <= 1'b0;
    end else begin
      null_tgl_q <= null_tgl_d;
      fct_tgl_q  <= fct_tgl_d;
      err_tgl_q  <= err_tgl_d;
    end
  end

  // ---------------- Crossings into clk ----------------

  logic null_ev;   // NULL received
  logic fct_ev;    // FCT received
  logic err_ev;    // Receive error
  logic d_ev;      // Transition on data pin
  logic s_ev;      // Transition on strobe pin

  edge_cross u_null (
    .clk      (clk),
    .rst      (rst),
    .level_in (null_tgl_q),
    .change_q (null_ev)
  );
  edge_cross u_fct (
    .clk      (clk),
    .rst      (rst),
    .level_in (fct_tgl_q),
    .change_q (fct_ev)
  );
  edge_cross u_err (
    .clk      (clk),
    .rst      (rst),
    .level_in (err_tgl_q),
    .change_q (err_ev)
  );
  edge_cross u_din (
    .clk      (clk),
    .rst      (rst),
    .level_in (d_in),
    .change_q (d_ev)
  );
  edge_cross u_sin (
    .clk      (clk),
    .rst      (rst),
    .level_in (s_in),
    .change_q (s_ev)
  );

  // ---------------- System clock domain ----------------

  link_state_t        state_d;                 // Next state
  logic [TIMER_W-1:0] timer_q, timer_d;        // State timer
  logic [DISC_W-1:0]  disc_cnt_q, disc_cnt_d;  // Idle line count
  logic               armed_q, armed_d;        // First bit seen
  logic               disc_q, disc_d;          // Disconnect found
  logic               got_null_q, got_null_d;  // NULL seen
  logic               tx_en_d, tx_null_d, tx_fct_d;
  logic               fct_accept_d, running_d, link_err_d;
  logic               line_ev;                 // Any D/S change
  logic               fault;                   // Reset cause
  logic               start_to;                // Wait expired

  // Next state, timers and receiver flags
  always_comb begin
    line_ev    = d_ev | s_ev;
    state_d    = state_q;
    link_err_d = 1'b0;
    timer_d    = (timer_q == '1) ? timer_q : timer_q + 1'b1;
    // Arm on any bit or NULL, never on silence
    armed_d    = armed_q | line_ev | null_ev;
    got_null_d = got_null_q | null_ev;
    // Idle count restarts on every transition
    if (line_ev || !armed_q) begin
      disc_cnt_d = '0;
    end else if (disc_cnt_q != DISC_LAST) begin
      disc_cnt_d = disc_cnt_q + 1'b1;
    end else begin
      disc_cnt_d = disc_cnt_q;
    end
    // Held until the receiver is reset
    disc_d   = disc_q | (disc_cnt_q == DISC_LAST);
    // Parity-type errors only count after a NULL
    fault    = disc_q | (err_ev & got_null_q);
    start_to = timer_done(timer_q, START_LAST);
    case (state_q)
      // Silent wait, receiver held in reset
      ST_ERR_RESET: begin
        if (timer_done(timer_q, RST_LAST)) begin
          state_d = ST_ERR_WAIT;
        end
      end
      // Receiver listens, anything unexpected resets
      ST_ERR_WAIT: begin
        if (fault || fct_ev) begin
          state_d = ST_ERR_RESET;
        end else if (timer_done(timer_q, WAIT_LAST)) begin
          state_d = ST_READY;
        end
      end
      // Waits for the host enable
      ST_READY: begin
        if (fault || fct_ev) begin
          state_d = ST_ERR_RESET;
        end else if (link_en) begin
          state_d = ST_STARTED;
        end
      end
      // Sends NULLs, waits for one back
      ST_STARTED: begin
        if (fault || fct_ev || start_to) begin
          state_d = ST_ERR_RESET;
        end else if (got_null_q) begin
          state_d = ST_CONNECTING;
        end
      end
      // Sends FCTs, waits for one back
      ST_CONNECTING: begin
        if (fault || start_to) begin
          state_d = ST_ERR_RESET;
        end else if (fct_ev) begin
          state_d = ST_RUN;
        end
      end
      // Only here is an error reported upward
      ST_RUN: begin
        if (fault) begin
          link_err_d = 1'b1;
          state_d    = ST_ERR_RESET;
        end else if (!link_en) begin
          state_d = ST_ERR_RESET;
        end
      end
      default: begin
        state_d = ST_ERR_RESET;
      end
    endcase
    // Every state starts its wait from zero
    if (state_d != state_q) begin
      timer_d = '0;
    end
    // Receiver and disconnect timer held clear in ErrorReset
    if (state_d == ST_ERR_RESET) begin
      disc_cnt_d = '0;
      disc_d     = 1'b0;
      armed_d    = 1'b0;
      got_null_d = 1'b0;
    end
    // Outputs follow the next state so they align with state_q
    tx_en_d      = tx_state(state_d);
    tx_null_d    = tx_state(state_d);
    fct_accept_d = (state_d == ST_CONNECTING) ||
                   (state_d == ST_RUN);
    tx_fct_d     = fct_accept_d & got_null_d;
    running_d    = (state_d == ST_RUN);
  end

  // State and flag registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q      <= STATE_RST;
      timer_q      <= '0;
      disc_cnt_q   <= '0;
      armed_q      <= 1'b0;
      disc_q       <= 1'b0;
      got_null_q   <= 1'b0;
      tx_en_q      <= 1'b0;
      tx_null_q    <= 1'b0;
      tx_fct_q     <= 1'b0;
      fct_accept_q <= 1'b0;
      running_q    <= 1'b0;
      link_err_q   <= 1'b0;
    end else begin
      state_q      <= state_d;
      timer_q      <= timer_d;
      disc_cnt_q   <= disc_cnt_d;
      armed_q      <= armed_d;
      disc_q       <= disc_d;
      got_null_q   <= got_null_d;
      tx_en_q      <= tx_en_d;
      tx_null_q    <= tx_null_d;
      tx_fct_q     <= tx_fct_d;
      fct_accept_q <= fct_accept_d;
      running_q    <= running_d;
      link_err_q   <= link_err_d;
    end
  end

  // ---------------- Checks ----------------

  chk_no_disc_unarmed: assert property (
    @(posedge clk) disable iff (rst)
    !armed_q |=> !disc_q)
    else $error("disconnect flagged before any bit arrived");

  chk_tx_silent_reset: assert property (
    @(posedge clk) disable iff (rst)
    state_q == ST_ERR_RESET |-> !tx_en_q && !tx_fct_q)
    else $error("transmitter active in ErrorReset");

  chk_start_timeout: assert property (
    @(posedge clk) disable iff (rst)
    state_q == ST_STARTED && timer_q == START_LAST && !got_null_q
    |=> state_q == ST_ERR_RESET)
    else $error("Started did not time out");

  chk_start_window: assert property (
    @(posedge clk) disable iff (rst)
    state_q == ST_STARTED |-> timer_q <= START_LAST)
    else $error("Started outlived its timeout");

  chk_null_advance: assert property (
    @(posedge clk) disable iff (rst)
    state_q == ST_STARTED && got_null_q && !fault && !fct_ev
    && !start_to |=> state_q == ST_CONNECTING)
    else $error("got NULL did not advance to Connecting");

  chk_disc_resets: assert property (
    @(posedge clk) disable iff (rst)
    disc_q && state_q != ST_ERR_RESET |=> state_q == ST_ERR_RESET)
    else $error("disconnect did not force ErrorReset");

  chk_connect_tx: assert property (
    @(posedge clk) disable iff (rst)
    state_q == ST_CONNECTING |-> tx_null_q && tx_fct_q && fct_accept_q)
    else $error("Connecting not sending or accepting FCTs");

  chk_fct_after_null: assert property (
    @(posedge clk) disable iff (rst)
    tx_fct_q |-> got_null_q)
    else $error("FCT sent before a NULL arrived");

  chk_reset_order: assert property (
    @(posedge clk) disable iff (rst)
    state_q == ST_ERR_RESET |=> state_q inside {ST_ERR_RESET, ST_ERR_WAIT})
    else $error("ErrorReset left for the wrong state");

  chk_disc_time: assert property (
    @(posedge clk) disable iff (rst)
    armed_q && !disc_q && state_d != ST_ERR_RESET && !line_ev
    && disc_cnt_q == DISC_LAST |=> disc_q)
    else $error("idle line not declared a disconnect");

  chk_err_in_run: assert property (
    @(posedge clk) disable iff (rst)
    link_err_q |-> $past(state_q) == ST_RUN && state_q == ST_ERR_RESET)
    else $error("link error reported outside Run");

  chk_ready_start: assert property (
    @(posedge clk) disable iff (rst)
    state_q == ST_READY && link_en && !fault && !fct_ev
    |=> state_q == ST_STARTED)
    else $error("enabled Ready did not start");

  chk_timers_clear: assert property (
    @(posedge clk) disable iff (rst)
    state_q == ST_ERR_RESET && $past(state_q) != ST_ERR_RESET
    |-> timer_q == '0 && disc_cnt_q == '0 && !got_null_q)
    else $error("timers not cleared entering ErrorReset");

endmodule : link_init_fsm

// file: rtl/link_init_pkg.sv
// Shared constants and state type for the link start-up state machine.
// Assumes a 10 MHz system clock; all timing counts derive from it.
//
// Behaviour
// - Disconnect detection armed only after first bit
// - ErrorReset silences the transmitter
// - Started leaves for ErrorReset on timeout/disconnect
// - Start timeout nominally 12.8 us
// - NULL arms timer, sets flag; advance
// - Disconnect in init states forces ErrorReset
// - Connecting sends NULLs, FCTs; accepts FCTs
// - No FCTs before a NULL arrives
// - Reset sequence; restart only when enabled
// - Broken cable keeps the sequence cycling
// - No D/S transition for 850 ns: disconnect
// - Only errors in Run reported upward
// - Ready and enabled moves to Started

package link_init_pkg;

  // System clock period
  localparam int CLK_PERIOD_NS = 100;

  // Times in nanoseconds, figures as printed
  localparam int RESET_WAIT_NS = 6400;   // 6.4 us in ErrorReset
  localparam int ERR_WAIT_NS   = 12800;  // 12.8 us in ErrorWait
  localparam int START_WAIT_NS = 12800;  // 12.8 us start timeout
  localparam int DISC_TIME_NS  = 850;    // Disconnect-detection time

  // Least times round up to whole cycles
  localparam int RESET_WAIT_CYC =
    (RESET_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERR_WAIT_CYC =
    (ERR_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Timeouts and disconnect limit round down
  localparam int START_WAIT_CYC = START_WAIT_NS / CLK_PERIOD_NS;
  localparam int DISC_TIME_CYC  = DISC_TIME_NS / CLK_PERIOD_NS;

  // Default counter widths
  localparam int TIMER_W_DEF = 8;
  localparam int DISC_W_DEF  = 4;

  // Exchange-level states
  typedef enum logic [2:0] {
    ST_ERR_RESET,
    ST_ERR_WAIT,
    ST_READY,
    ST_STARTED,
    ST_CONNECTING,
    ST_RUN
  } link_state_t;

  // Value after reset
  localparam link_state_t STATE_RST = ST_ERR_RESET;

endpackage : link_init_pkg

// file: tb/far_end.sv
// Far-end link interface model: recovered link clock, decoded events
// and raw data/strobe activity, as seen by the local start-up block.
// Assumes the bench raises talk while the far transmitter is running.
`timescale 1ns/1ps

module far_end (
  // Bench control
  input  wire logic talk,
  // Toward the local block
  output logic      link_clk,
  output logic      rx_null_l,
  output logic      rx_fct_l,
  output logic      rx_err_l,
  output logic      d_out,
  output logic      s_out
);
  logic       osc;     // Free 48 ns oscillator, own phase
  logic       talk_g;  // Gate, changed only while osc is low
  logic [2:0] div;     // Link clocks spent in the current bit
  logic       sel;     // Line that changes at the next bit

  initial begin
    osc       = 1'b0;
    talk_g    = 1'b0;
    div       = 3'h0;
    sel       = 1'b0;
    rx_null_l = 1'b0;
    rx_fct_l  = 1'b0;
    rx_err_l  = 1'b0;
    d_out     = 1'b0;
    s_out     = 1'b0;
    #7;
    forever #24 osc = ~osc;
  end

  // Gate on the low phase so the clock never glitches
  always @(negedge osc) talk_g <= talk;

  // Recovered clock stands still while the far side is silent
  assign link_clk = osc & talk_g;

  // One line changes per bit, data and strobe in turn; a bit lasts six
  // link clocks so the 10 MHz synchroniser sees every level without
  // aliasing; silence leaves both lines still
  always @(posedge link_clk) begin
    if (div == 3'h5) begin
      div <= 3'h0;
      sel <= ~sel;
      if (sel) begin
        d_out <= ~d_out;
      end else begin
        s_out <= ~s_out;
      end
    end else begin
      div <= div + 3'h1;
    end
  end

  // One link-clock pulse per decoded character of the given kind
  task automatic send(input int kind);
    @(posedge link_clk);
    rx_null_l <= (kind == 0);
    rx_fct_l  <= (kind == 1);
    rx_err_l  <= (kind == 2);
    @(posedge link_clk);
    rx_null_l <= 1'b0;
    rx_fct_l  <= 1'b0;
    rx_err_l  <= 1'b0;
  endtask : send
endmodule : far_end

// file: tb/testbench.sv
// Self-checking bench for the link start-up and recovery machine.
// Assumes the far_end model as the only source of link activity.
`timescale 1ns/1ps

module testbench;
  import link_init_pkg::*;

  logic        clk, rst, link_en, talk;     // Bench-driven controls
  logic        link_clk, rx_null_l, rx_fct_l, rx_err_l, d_in, s_in;
  logic        tx_en_q, tx_null_q, tx_fct_q, fct_accept_q;
  logic        running_q, link_err_q;       // Status outputs
  link_state_t state_q;                     // Current exchange state
  int          mismatches, checks, cycles, n;
  logic        err_seen;                    // Link error pulse seen

  link_init_fsm dut (
    .clk(clk), .rst(rst), .link_en(link_en), .link_clk(link_clk),
    .rx_null_l(rx_null_l), .rx_fct_l(rx_fct_l), .rx_err_l(rx_err_l),
    .d_in(d_in), .s_in(s_in), .tx_en_q(tx_en_q), .tx_null_q(tx_null_q),
    .tx_fct_q(tx_fct_q), .fct_accept_q(fct_accept_q),
    .running_q(running_q), .link_err_q(link_err_q), .state_q(state_q)
  );

  far_end far (
    .talk(talk), .link_clk(link_clk), .rx_null_l(rx_null_l),
    .rx_fct_l(rx_fct_l), .rx_err_l(rx_err_l), .d_out(d_in), .s_out(s_in)
  );

  // 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard; the full run needs about 1600 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  // Catch the one-cycle error pulse where it is settled
  always @(negedge clk) if (link_err_q === 1'b1) err_seen = 1'b1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Wait, bounded, for a state; k returns the cycles spent
  task automatic wait_st(input link_state_t s, input int lim,
                         output int k);
    k = 0;
    while (state_q !== s && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_st

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  // Reset sequence timing, then a silent far end is no disconnect
  task automatic t_reset;
    int bad;
    bad = 0;
    wait_st(ST_ERR_WAIT, 100, n);
    check(n >= 63 && n <= 65, 1);
    check(tx_en_q, 1'b0);
    wait_st(ST_READY, 200, n);
    check(n >= 127 && n <= 129, 1);
    repeat (200) begin
      @(negedge clk);
      if (state_q !== ST_READY) bad++;
    end
    check(bad, 0);
    $display("t_reset done");
  endtask : t_reset

  // Enabled against a silent far end: timeout and endless cycling
  task automatic t_timeout;
    link_en = 1'b1;
    for (int i = 0; i < 2; i++) begin
      wait_st(ST_STARTED, 300, n);
      @(negedge clk);
      check(state_q, ST_STARTED);
      check({tx_en_q, tx_null_q, tx_fct_q, fct_accept_q}, 4'hC);
      wait_st(ST_ERR_RESET, 200, n);
      check(n >= 126 && n <= 129, 1);
      check({tx_en_q, tx_null_q}, 2'h0);
    end
    $display("t_timeout done");
  endtask : t_timeout

  // NULL leads to Connecting; far silence there is a disconnect
  task automatic t_connect;
    wait_st(ST_STARTED, 300, n);
    err_seen = 1'b0;
    talk = 1'b1;
    far.send(0);
    wait_st(ST_CONNECTING, 20, n);
    check(state_q, ST_CONNECTING);
    check({tx_fct_q, fct_accept_q, tx_en_q}, 3'h7);
    talk = 1'b0;
    wait_st(ST_ERR_RESET, 40, n);
    check(state_q, ST_ERR_RESET);
    check(n >= 8 && n <= 20, 1);
    check(err_seen, 1'b0);
    $display("t_connect done");
  endtask : t_connect

  // Full start-up to Run, then a receive error is reported
  task automatic t_run;
    wait_st(ST_STARTED, 300, n);
    talk = 1'b1;
    far.send(0);
    wait_st(ST_CONNECTING, 20, n);
    repeat (12) @(negedge clk);
    far.send(1);
    wait_st(ST_RUN, 20, n);
    check(running_q, 1'b1);
    err_seen = 1'b0;
    far.send(2);
    wait_st(ST_ERR_RESET, 20, n);
    check({state_q, running_q, tx_en_q}, {ST_ERR_RESET, 2'h0});
    // Pulse catcher runs on the same edge; let it settle first
    @(negedge clk);
    check(err_seen, 1'b1);
    talk = 1'b0;
    $display("t_run done");
  endtask : t_run

  // Activity then silence while waiting in ErrorWait and in Ready
  task automatic t_wait_disc;
    link_state_t s;
    link_en = 1'b0;
    for (int i = 0; i < 2; i++) begin
      s = (i == 0) ? ST_ERR_WAIT : ST_READY;
      wait_st(ST_ERR_RESET, 300, n);
      wait_st(s, 300, n);
      talk = 1'b1;
      repeat (20) @(negedge clk);
      talk = 1'b0;
      wait_st(ST_ERR_RESET, 40, n);
      check(state_q, ST_ERR_RESET);
    end
    $display("t_wait_disc done");
  endtask : t_wait_disc

  // Main sequence: inputs change on the falling edge
  initial begin
    rst        = 1'b1;
    link_en    = 1'b0;
    talk       = 1'b0;
    err_seen   = 1'b0;
    mismatches = 0;
    checks     = 0;
    cycles     = 0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_timeout();
    t_connect();
    t_run();
    t_wait_disc();
    conclude();
  end
endmodule : testbench
